// *** tbcr_top.sv ***
/*
 * Timebase generation and routing fabric with a paired counter chain.
 * Assumes all inputs are synchronous to ref_clk; timebases are carried
 * as one-cycle ticks of ref_clk rather than as separate clocks.
 */
`timescale 1ns/10ps
module tbcr_top
    import tbcr_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Timebase inputs
    input  wire logic        syncLineSeven,
    input  wire logic        fasterTick,
    // Sample and conversion clocks
    output logic             inputSampleClock,
    output logic             outputSampleClock,
    output logic             inputConversionClock,
    // Events
    input  wire logic        holdDoneEvent,
    output logic             holdDoneConnectorPin,
    input  wire logic        compareRaw,
    output logic             compareEnable,
    output logic             levelCompareEvent,
    // Counters and trigger bus
    input  wire logic [1:0]  counterSourceIn,
    output logic [1:0]       counterInternalOutput,
    output logic [1:0]       partnerCounterOutput,
    output logic [1:0]       partnerCounterPulse,
    input  wire logic        ctrZeroPinIn,
    output logic             ctrZeroPinOut,
    output logic             ctrZeroPinOe,
    output logic             trigBusOut,
    output logic             trigBusOe
);
    import tbcr_pkg::*;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    tbcr_bus_t          busState_q, busState_d;
    logic [31:0]        readData_q, readData_d;
    logic [CS_WIDTH-1:0] clkSel_q, clkSel_d;
    logic [15:0]        div_q [3];
    logic [15:0]        div_d [3];
    logic [31:0]        ctrCfg_q [2];
    logic [31:0]        ctrCfg_d [2];
    logic               selErr_q, selErr_d;
    logic               wrAccept;
    logic [15:0]        ctrCnt_q [2];
    logic [1:0]         ctrTog_q;

    function automatic logic selfRoute(input logic [31:0] v);
        selfRoute = (v[CS_IN_SRC+:2] == SRC_SELF) || (v[CS_OUT_SRC+:2] == SRC_SELF)
                 || (v[CS_CONV_SRC+:2] == SRC_SELF);
    endfunction

    assign avs_waitrequest = (avs_read || avs_write) && (busState_q == BUS_IDLE);
    assign avs_readdata    = readData_q;
    assign wrAccept        = avs_write && (busState_q == BUS_ANSWER);

    always_comb begin
        busState_d = BUS_IDLE;
        if ((avs_read || avs_write) && busState_q == BUS_IDLE) begin
            busState_d = BUS_ANSWER;
        end
        readData_d = readData_q;
        if (avs_read && busState_q == BUS_IDLE) begin
            unique case (avs_address)
                OFS_CLK_SEL:  readData_d = {19'h0, clkSel_q};
                OFS_DIV_IN:   readData_d = {16'h0, div_q[0]};
                OFS_DIV_OUT:  readData_d = {16'h0, div_q[1]};
                OFS_DIV_CONV: readData_d = {16'h0, div_q[2]};
                OFS_CTR0_CFG: readData_d = ctrCfg_q[0];
                OFS_CTR1_CFG: readData_d = ctrCfg_q[1];
                OFS_CTR0_CNT: readData_d = {16'h0, ctrCnt_q[0]};
                OFS_CTR1_CNT: readData_d = {16'h0, ctrCnt_q[1]};
                OFS_STATUS:   readData_d = {28'h0, compareEnable, ctrTog_q, selErr_q};
                default:      readData_d = 32'h0000_0000;
            endcase
        end
        clkSel_d = clkSel_q;
        div_d    = div_q;
        ctrCfg_d = ctrCfg_q;
        selErr_d = selErr_q;
        // Status write of one clears the error; a new rejection wins
        if (wrAccept && avs_address == OFS_STATUS && avs_writedata[0]) begin
            selErr_d = 1'b0;
        end
        if (wrAccept) begin
            unique case (avs_address)
                OFS_CLK_SEL: begin
                    if (selfRoute(avs_writedata)) begin
                        selErr_d = 1'b1;
                    end else begin
                        clkSel_d = avs_writedata[CS_WIDTH-1:0];
                    end
                end
                OFS_DIV_IN:   div_d[0]    = avs_writedata[15:0];
                OFS_DIV_OUT:  div_d[1]    = avs_writedata[15:0];
                OFS_DIV_CONV: div_d[2]    = avs_writedata[15:0];
                OFS_CTR0_CFG: ctrCfg_d[0] = avs_writedata;
                OFS_CTR1_CFG: ctrCfg_d[1] = avs_writedata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busState_q <= BUS_IDLE;
            readData_q <= 32'h0000_0000;
            clkSel_q   <= CS_RESET;
            div_q      <= '{DIV_RESET, DIV_RESET, DIV_RESET};
            ctrCfg_q   <= '{CC_RESET, CC_RESET};
            selErr_q   <= 1'b0;
        end else begin
            busState_q <= busState_d;
            readData_q <= readData_d;
            clkSel_q   <= clkSel_d;
            div_q      <= div_d;
            ctrCfg_q   <= ctrCfg_d;
            selErr_q   <= selErr_d;
        end
    end

    // ------------------------------------------------------------
    // Timebases
    // ------------------------------------------------------------
    logic [2:0] fastCnt_q, fastCnt_d;
    logic [7:0] slowCnt_q, slowCnt_d;
    logic       slowTick_q, slowTick_d;
    logic       syncPrev_q;
    logic       fastTick, syncEdge, primTick, fixedTb;

    assign fastTick = (fastCnt_q == FAST_CNT_LAST);
    assign syncEdge = syncLineSeven && !syncPrev_q;
    assign fixedTb  = clkSel_q[CS_FIXED_TB];
    // External reference enters the primary timebase only through sync line seven
    assign primTick = (clkSel_q[CS_PRIM_SYNC] && !fixedTb) ? syncEdge : fastTick;

    always_comb begin
        fastCnt_d  = fastTick ? 3'h0 : fastCnt_q + 3'h1;
        slowCnt_d  = slowCnt_q;
        slowTick_d = 1'b0;
        if (fastTick) begin
            // Free running; no enable so the slow base never drifts
            slowCnt_d  = (slowCnt_q == SLOW_CNT_LAST) ? 8'h00 : slowCnt_q + 8'h01;
            slowTick_d = (slowCnt_q == SLOW_CNT_LAST);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fastCnt_q  <= 3'h0;
            slowCnt_q  <= 8'h00;
            slowTick_q <= 1'b0;
            syncPrev_q <= 1'b0;
        end else begin
            fastCnt_q  <= fastCnt_d;
            slowCnt_q  <= slowCnt_d;
            slowTick_q <= slowTick_d;
            syncPrev_q <= syncLineSeven;
        end
    end

    // ------------------------------------------------------------
    // Sample and conversion clocks: 0 input, 1 output, 2 conversion
    // ------------------------------------------------------------
    logic [2:0]  baseTick, sampPulse_q, sampPulse_d;
    logic [15:0] sampCnt_q [3];
    logic [15:0] sampCnt_d [3];
    localparam int unsigned SRC_POS [3] = '{CS_IN_SRC, CS_OUT_SRC, CS_CONV_SRC};

    for (genvar g = 0; g < 3; g++) begin : g_samp
        always_comb begin
            unique case (clkSel_q[SRC_POS[g]+:2])
                SRC_SLOW: baseTick[g] = slowTick_q;
                SRC_FAST: baseTick[g] = fixedTb ? fasterTick : fastTick;
                default:  baseTick[g] = primTick;
            endcase
            sampCnt_d[g]   = sampCnt_q[g];
            sampPulse_d[g] = 1'b0;
            if (baseTick[g]) begin
                // Divisor of zero acts as one
                if (sampCnt_q[g] + 16'h0001 >= div_q[g]) begin
                    sampCnt_d[g]   = 16'h0000;
                    sampPulse_d[g] = 1'b1;
                end else begin
                    sampCnt_d[g] = sampCnt_q[g] + 16'h0001;
                end
            end
        end
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                sampCnt_q[g]   <= 16'h0000;
                sampPulse_q[g] <= 1'b0;
            end else begin
                sampCnt_q[g]   <= sampCnt_d[g];
                sampPulse_q[g] <= sampPulse_d[g];
            end
        end
    end

    assign inputSampleClock     = sampPulse_q[0];
    assign outputSampleClock    = sampPulse_q[1];
    assign inputConversionClock = sampPulse_q[2];

    // ------------------------------------------------------------
    // Events and trigger bus routing
    // ------------------------------------------------------------
    logic holdPin_q, compEvt_q, busOut_q, pinOut_q;
    tbcr_trig_t trigMode;

    assign trigMode      = tbcr_trig_t'(clkSel_q[CS_TRIG_MODE+:2]);
    assign compareEnable = (trigMode == TRIG_EDGE) || (trigMode == TRIG_WINDOW);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            holdPin_q <= 1'b0;
            compEvt_q <= 1'b0;
            busOut_q  <= 1'b0;
            pinOut_q  <= 1'b0;
        end else begin
            holdPin_q <= clkSel_q[CS_HOLD_PIN] && holdDoneEvent;
            compEvt_q <= compareEnable && compareRaw;
            busOut_q  <= ctrZeroPinIn;
            pinOut_q  <= counterInternalOutput[0];
        end
    end

    assign holdDoneConnectorPin = holdPin_q;
    assign levelCompareEvent    = compEvt_q;
    // Pin turns around to input while it feeds the trigger bus
    assign ctrZeroPinOe  = !clkSel_q[CS_CTR0_BUS];
    assign ctrZeroPinOut = pinOut_q;
    assign trigBusOe     = clkSel_q[CS_CTR0_BUS];
    assign trigBusOut    = busOut_q;

    // ------------------------------------------------------------
    // Paired counters
    // ------------------------------------------------------------
    logic [1:0]  ctrTick, ctrTc, ctrPulse_q, ctrPulse_d, ctrTog_d;
    logic [15:0] ctrCnt_d [2];

    for (genvar c = 0; c < 2; c++) begin : g_ctr
        always_comb begin
            unique case (ctrCfg_q[c][CC_SRC+:2])
                CSRC_SLOW:     ctrTick[c] = slowTick_q;
                CSRC_PARTNER:  ctrTick[c] = ctrPulse_q[1-c];
                CSRC_EXTERNAL: ctrTick[c] = counterSourceIn[c];
                default:       ctrTick[c] = primTick;
            endcase
            ctrTc[c] = ctrCfg_q[c][CC_UP] ? (ctrCnt_q[c] == 16'hffff)
                                          : (ctrCnt_q[c] == 16'h0000);
            ctrCnt_d[c]   = ctrCnt_q[c];
            ctrPulse_d[c] = 1'b0;
            ctrTog_d[c]   = ctrTog_q[c];
            if (!ctrCfg_q[c][CC_ENABLE]) begin
                ctrCnt_d[c] = ctrCfg_q[c][CC_LOAD+:16];
            end else if (ctrTick[c]) begin
                if (ctrTc[c]) begin
                    // Pulse is set for one ref cycle per terminal count, whatever the source rate
                    ctrPulse_d[c] = 1'b1;
                    ctrTog_d[c]   = !ctrTog_q[c];
                    ctrCnt_d[c]   = ctrCfg_q[c][CC_LOAD+:16];
                end else begin
                    ctrCnt_d[c] = ctrCfg_q[c][CC_UP] ? ctrCnt_q[c] + 16'h0001
                                                     : ctrCnt_q[c] - 16'h0001;
                end
            end
        end
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                ctrCnt_q[c]   <= 16'h0000;
                ctrPulse_q[c] <= 1'b0;
                ctrTog_q[c]   <= 1'b0;
            end else begin
                ctrCnt_q[c]   <= ctrCnt_d[c];
                ctrPulse_q[c] <= ctrPulse_d[c];
                ctrTog_q[c]   <= ctrTog_d[c];
            end
        end
        assign counterInternalOutput[c] = ctrCfg_q[c][CC_TOGGLE] ? ctrTog_q[c]
                                                                : ctrPulse_q[c];
        assign partnerCounterOutput[c]  = counterInternalOutput[1-c];
        assign partnerCounterPulse[c]   = ctrPulse_q[1-c];
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_fast_rate: assert property (fastTick |=> !fastTick [*4] ##1 fastTick)
        else $error("fast reference tick not every fifth cycle");
    a_prim_sync: assert property ($rose(syncLineSeven) && clkSel_q[CS_PRIM_SYNC] && !fixedTb
        |-> primTick)
        else $error("sync line edge did not reach primary timebase");
    a_slow_divide: assert property (fastTick && slowCnt_q == SLOW_CNT_LAST
        |=> slowTick_q && slowCnt_q == 8'h00)
        else $error("slow timebase not produced at count 199");
    a_slow_gap: assert property (slowTick_q |=> !slowTick_q [*8])
        else $error("slow timebase ticked too soon");
    a_self_reject: assert property (wrAccept && avs_address == OFS_CLK_SEL
        && selfRoute(avs_writedata) |=> selErr_q && $stable(clkSel_q))
        else $error("self routing selection was accepted");
    a_default_base: assert property (clkSel_q[CS_IN_SRC+:2] == SRC_DEFAULT && div_q[0] == 16'h0001
        && primTick |=> inputSampleClock)
        else $error("default base did not clock the input sample clock");
    a_tc_down: assert property (ctrCfg_q[0][CC_ENABLE] && !ctrCfg_q[0][CC_UP] && ctrTick[0]
        && ctrCnt_q[0] == 16'h0000 |=> partnerCounterPulse[1])
        else $error("counter zero missed terminal count pulse");
    a_tc_reload: assert property (ctrPulse_q[1] |-> ctrCnt_q[1] == $past(ctrCfg_q[1][31:16]))
        else $error("counter one did not reload at terminal count");
    a_toggle_flip: assert property (ctrPulse_q[0] |-> ctrTog_q[0] != $past(ctrTog_q[0]))
        else $error("toggle output did not flip");
    a_chain_clock: assert property (ctrPulse_q[1] && ctrCfg_q[0][CC_ENABLE]
        && ctrCfg_q[0][CC_SRC+:2] == CSRC_PARTNER |=> $changed(ctrCnt_q[0]) || ctrPulse_q[0])
        else $error("partner pulse did not clock counter zero");
    a_comp_gate: assert property (levelCompareEvent |-> $past(compareEnable) && $past(compareRaw))
        else $error("compare event while comparator disabled");
    a_hold_route: assert property (holdDoneEvent && clkSel_q[CS_HOLD_PIN] |=> holdDoneConnectorPin)
        else $error("hold-done event not routed to pin");

    c_read_done: cover property (avs_read && !avs_waitrequest);
    c_cascade:   cover property (ctrPulse_q[1] ##[1:1000] ctrPulse_q[0]);
    c_reject:    cover property ($rose(selErr_q));
    c_sync_src:  cover property (clkSel_q[CS_PRIM_SYNC] && primTick ##1 inputSampleClock);
endmodule

// *** tbcr_pkg.sv ***
/*
 * Shared constants for the timebase and counter chain routing block:
 * register offsets, field positions, reset values and cycle counts.
 * Assumes a single 100 MHz reference clock drives the whole block.
 */
package tbcr_pkg;
    // ------------------------------------------------------------
    // Clock rates and divider counts
    // ------------------------------------------------------------
    localparam int unsigned REF_CLK_KHZ   = 100000;
    localparam int unsigned FAST_REF_KHZ  = 20000;
    localparam int unsigned SLOW_TB_KHZ   = 100;
    localparam int unsigned FAST_DIV      = REF_CLK_KHZ / FAST_REF_KHZ;
    localparam int unsigned SLOW_DIV      = FAST_REF_KHZ / SLOW_TB_KHZ;
    localparam logic [2:0]  FAST_CNT_LAST = 3'(FAST_DIV - 1);
    localparam logic [7:0]  SLOW_CNT_LAST = 8'(SLOW_DIV - 1);

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_CLK_SEL   = 6'h00;
    localparam logic [5:0] OFS_DIV_IN    = 6'h04;
    localparam logic [5:0] OFS_DIV_OUT   = 6'h08;
    localparam logic [5:0] OFS_DIV_CONV  = 6'h0c;
    localparam logic [5:0] OFS_CTR0_CFG  = 6'h10;
    localparam logic [5:0] OFS_CTR1_CFG  = 6'h14;
    localparam logic [5:0] OFS_CTR0_CNT  = 6'h18;
    localparam logic [5:0] OFS_CTR1_CNT  = 6'h1c;
    localparam logic [5:0] OFS_STATUS    = 6'h20;

    // ------------------------------------------------------------
    // Clock select register fields
    // ------------------------------------------------------------
    localparam int unsigned CS_PRIM_SYNC = 0;
    localparam int unsigned CS_IN_SRC    = 2;
    localparam int unsigned CS_OUT_SRC   = 4;
    localparam int unsigned CS_CONV_SRC  = 6;
    localparam int unsigned CS_HOLD_PIN  = 8;
    localparam int unsigned CS_TRIG_MODE = 9;
    localparam int unsigned CS_CTR0_BUS  = 11;
    localparam int unsigned CS_FIXED_TB  = 12;
    localparam int unsigned CS_WIDTH     = 13;
    localparam logic [12:0] CS_RESET     = 13'h0000;

    // Timebase source codes of the three sample/convert muxes
    localparam logic [1:0] SRC_DEFAULT   = 2'h0;
    localparam logic [1:0] SRC_SLOW      = 2'h1;
    localparam logic [1:0] SRC_FAST      = 2'h2;
    localparam logic [1:0] SRC_SELF      = 2'h3;

    // ------------------------------------------------------------
    // Counter config register fields
    // ------------------------------------------------------------
    localparam int unsigned CC_ENABLE    = 0;
    localparam int unsigned CC_UP        = 1;
    localparam int unsigned CC_TOGGLE    = 2;
    localparam int unsigned CC_SRC       = 3;
    localparam int unsigned CC_LOAD      = 16;
    localparam logic [15:0] DIV_RESET    = 16'h0001;
    localparam logic [31:0] CC_RESET     = 32'h0000_0000;

    // Counter clock source codes
    localparam logic [1:0] CSRC_PRIMARY  = 2'h0;
    localparam logic [1:0] CSRC_SLOW     = 2'h1;
    localparam logic [1:0] CSRC_PARTNER  = 2'h2;
    localparam logic [1:0] CSRC_EXTERNAL = 2'h3;

    typedef enum logic [1:0] {TRIG_NONE, TRIG_EDGE, TRIG_WINDOW, TRIG_RSVD} tbcr_trig_t;
    typedef enum logic {BUS_IDLE, BUS_ANSWER} tbcr_bus_t;
endpackage

// *** tbcr_far_model.sv ***
/*
 * Far-side model: sync bus line seven, counter source ticks,
 * comparator level and the external driver of the counter zero pin.
 * Assumes the bench resolves the pin level from the DUT pin enable alone.
 */
`timescale 1ns/10ps
module tbcr_far_model #(
    parameter int SYNC_HALF = 4
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Far-side lines
    output logic            syncLineSeven,
    output logic [1:0]      counterSourceIn,
    output logic            compareRaw,
    output logic            farPin
);
    int n;
    // Shared reference only ever offered on line seven
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            n               <= 0;
            syncLineSeven   <= 1'b0;
            counterSourceIn <= 2'h0;
            compareRaw      <= 1'b0;
            farPin          <= 1'b0;
        end else begin
            n               <= n + 1;
            if (n % SYNC_HALF == SYNC_HALF - 1) syncLineSeven <= ~syncLineSeven;
            counterSourceIn <= {n % 7 == 0, n % 11 == 0};
            compareRaw      <= 1'($urandom);
            // Changes every cycle so a stale value is never mistaken for a drive
            farPin          <= ~farPin;
        end
    end
endmodule

// *** tbcr_tb_top.sv ***
/*
 * Self-checking bench for the timebase and counter routing block.
 * Assumes the Avalon slave answers on its own waitrequest only.
 */
`timescale 1ns/10ps
module tbcr_tb_top;
    import tbcr_pkg::*;
    localparam int HALF = 4;
    logic        ref_clk = 0, reset_n = 0, avRead = 0, avWrite = 0, holdIn = 0, fastTick = 0;
    logic [5:0]  avAddr = 0;
    logic [31:0] avWdata = 0, avRdata, q;
    logic        avWait, syncLine, cmpRaw, farPin, pinPrev, inS, outS, convS, holdPin;
    logic        cmpEn, cmpEv, pinOut, pinOe, busOut, busOe, rawPrev, outPrev;
    logic [1:0]  srcIn, ctrOut, partOut, partPulse, src;
    wire logic   pinLevel = pinOe ? pinOut : farPin;
    int          bad_count = 0, cmp_count = 0, p, n, ft = 0;

    always #5 ref_clk = ~ref_clk;
    // Faster timebase tick every third cycle
    always @(posedge ref_clk) begin
        {pinPrev, rawPrev, outPrev} <= {pinLevel, cmpRaw, ctrOut[0]};
        fastTick <= (ft == 2);
        ft       <= (ft == 2) ? 0 : ft + 1;
    end

    tbcr_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avAddr),
        .avs_read(avRead), .avs_write(avWrite), .avs_writedata(avWdata),
        .avs_readdata(avRdata), .avs_waitrequest(avWait), .syncLineSeven(syncLine),
        .fasterTick(fastTick), .inputSampleClock(inS), .outputSampleClock(outS),
        .inputConversionClock(convS), .holdDoneEvent(holdIn), .holdDoneConnectorPin(holdPin),
        .compareRaw(cmpRaw), .compareEnable(cmpEn), .levelCompareEvent(cmpEv),
        .counterSourceIn(srcIn), .counterInternalOutput(ctrOut),
        .partnerCounterOutput(partOut), .partnerCounterPulse(partPulse),
        .ctrZeroPinIn(pinLevel), .ctrZeroPinOut(pinOut), .ctrZeroPinOe(pinOe),
        .trigBusOut(busOut), .trigBusOe(busOe));
    tbcr_far_model #(.SYNC_HALF(HALF)) far (.ref_clk(ref_clk), .reset_n(reset_n),
        .syncLineSeven(syncLine), .counterSourceIn(srcIn), .compareRaw(cmpRaw),
        .farPin(farPin));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task end_sim;
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Holds the request until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        avAddr  <= a;
        avWdata <= d;
        avWrite <= w;
        avRead  <= !w;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            if (avWait === 1'b0) break;
        end
        q = avRdata;
        avWrite <= 1'b0;
        avRead  <= 1'b0;
        if (k == 50) begin
            bad_count++;
            end_sim;
        end
        @(posedge ref_clk);
    endtask

    function automatic logic sig(int s);
        case (s)
            0: return inS;
            1: return outS;
            2: return convS;
            3: return partPulse[1];
            4: return partPulse[0];
            default: return ctrOut[0];
        endcase
    endfunction

    function automatic int expPer(logic [1:0] s, int d);
        return (s == SRC_SLOW ? FAST_DIV * SLOW_DIV : FAST_DIV) * (d == 0 ? 1 : d);
    endfunction

    // Cycles between two rises; signals 0 to 4 must also drop after one cycle
    task automatic per(input int s);
        logic pv;
        int   k, i;
        pv = 1'b1;
        k  = 0;
        p  = 0;
        for (i = 0; i < 9000 && k < 2; i++) begin
            @(negedge ref_clk);
            if (k == 1) p++;
            if (sig(s) === 1'b1 && pv !== 1'b1) k++;
            pv = sig(s);
        end
        if (k < 2) begin
            bad_count++;
            end_sim;
        end
        if (s < 5) begin
            @(negedge ref_clk);
            chk("pulse width", 0, {31'h0, sig(s)});
        end
        @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(19237));
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        bus(0, OFS_CLK_SEL, 0); chk("clk_sel reset", {19'h0, CS_RESET}, q);
        bus(0, OFS_DIV_IN, 0); chk("div reset", {16'h0, DIV_RESET}, q);
        bus(0, 6'h24, 0); chk("unmapped", 0, q);
        per(0); chk("default in period", FAST_DIV, p);
        per(2); chk("default conv period", FAST_DIV, p);
        // Source codes 0 to 2 in every mux; divider 0 acts as 1
        for (int i = 0; i < 9; i++) begin
            src = 2'(i / 3);
            n   = (i == 0) ? 0 : (src == SRC_SLOW ? 1 : $urandom_range(1, 8));
            bus(1, OFS_CLK_SEL, 32'(src) << (CS_IN_SRC + 2 * (i % 3)));
            bus(1, OFS_DIV_IN + 6'(4 * (i % 3)), n);
            per(i % 3); chk("mux period", expPer(src, n), p);
        end
        bus(1, OFS_DIV_IN, 1);
        bus(1, OFS_CLK_SEL, 1);
        per(0); chk("sync line period", 2 * HALF, p);
        bus(1, OFS_CLK_SEL, 32'h10c);
        bus(0, OFS_CLK_SEL, 0); chk("self route kept", 1, q);
        bus(0, OFS_STATUS, 0); chk("self route flag", 1, {31'h0, q[0]});
        bus(1, OFS_STATUS, 1);
        bus(0, OFS_STATUS, 0); chk("flag cleared", 0, {31'h0, q[0]});
        // Fixed variant: primary ignores the sync line, fast code takes the faster tick
        bus(1, OFS_DIV_CONV, 1);
        bus(1, OFS_CLK_SEL, 32'h1009);
        per(0); chk("faster base period", 3, p);
        per(2); chk("fixed primary period", FAST_DIV, p);
        for (int m = 0; m < 4; m++) begin
            bus(1, OFS_CLK_SEL, 32'(m) << CS_TRIG_MODE);
            chk("compare enable", {31'h0, m == 1 || m == 2}, {31'h0, cmpEn});
            repeat (3) begin
                @(negedge ref_clk);
                chk("compare event", {31'h0, m[1] ^ m[0] && rawPrev}, {31'h0, cmpEv});
            end
            @(posedge ref_clk);
        end
        for (int e = 0; e < 2; e++) begin
            bus(1, OFS_CLK_SEL, 32'(e) << CS_HOLD_PIN);
            holdIn <= 1'b1;
            @(posedge ref_clk);
            holdIn <= 1'b0;
            @(negedge ref_clk);
            chk("hold pin", e, {31'h0, holdPin});
            @(posedge ref_clk);
        end
        bus(1, OFS_CLK_SEL, 32'h1 << CS_CTR0_BUS);
        repeat (4) begin
            @(negedge ref_clk);
            chk("bus drive", 32'h0000_0002, {30'h0, busOe, pinOe});
            chk("bus value", {31'h0, pinPrev}, {31'h0, busOut});
        end
        @(posedge ref_clk);
        bus(1, OFS_CLK_SEL, 0);
        bus(1, OFS_CTR0_CFG, 32'h0001_0001);
        bus(1, OFS_CTR1_CFG, 32'h0000_0011);
        per(3); chk("ctr0 wrap", 2 * FAST_DIV, p);
        per(4); chk("ctr1 cascade", 2 * FAST_DIV, p);
        per(5); chk("pulsed form", 2 * FAST_DIV, p);
        bus(1, OFS_CTR0_CFG, 32'h0001_0005);
        per(5); chk("toggled form", 4 * FAST_DIV, p);
        // Toggle level and partner pulse differ here, so a swapped pair shows
        repeat (3) begin
            @(negedge ref_clk);
            chk("partner out", {30'h0, ctrOut[0], ctrOut[1]}, {30'h0, partOut});
            chk("pin out", {31'h0, outPrev}, {31'h0, pinOut});
        end
        @(posedge ref_clk);
        // Counter zero on external ticks, counter one on the slow base
        bus(1, OFS_CTR0_CFG, 32'h0000_0019);
        bus(1, OFS_CTR1_CFG, 32'h0000_0009);
        per(3); chk("external source", 11, p);
        per(4); chk("slow source", FAST_DIV * SLOW_DIV, p);
        end_sim;
    end
endmodule
